/* rtc_twi_pkg.sv */
// Shared constants, types and helpers of the two-wire target interface
package rtc_twi_pkg;

  // ======================================================
  // Serial framing
  localparam logic [3:0] DEV_CODE = 4'h6;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] MACK_MARK = 4'h9;
  localparam int MEM_BYTES = 20;

  // ======================================================
  // Command codes
  localparam logic [2:0] CMD_STATUS1 = 3'h0;
  localparam logic [2:0] CMD_STATUS2 = 3'h1;
  localparam logic [2:0] CMD_RTD1 = 3'h2;
  localparam logic [2:0] CMD_RTD2 = 3'h3;
  localparam logic [2:0] CMD_INTD1 = 3'h4;
  localparam logic [2:0] CMD_INTD2 = 3'h5;
  localparam logic [2:0] CMD_CORR = 3'h6;
  localparam logic [2:0] CMD_FREE = 3'h7;
  localparam int ALARM_MODE_BIT = 5;

  // ======================================================
  // APB map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INDEX = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] CTRL_RST = 8'h01;

  typedef enum logic [2:0] {
    st_idle, st_addr, st_ack, st_wr, st_tx, st_mack, st_wait
  } link_state_t;

  // Byte store index of a command's first byte
  function automatic logic [4:0] base_of(input logic [2:0] cmd);
    case (cmd)
      CMD_STATUS1: base_of = 5'h00;
      CMD_STATUS2: base_of = 5'h01;
      CMD_RTD1: base_of = 5'h02;
      CMD_RTD2: base_of = 5'h09;
      CMD_INTD1: base_of = 5'h0C;
      CMD_INTD2: base_of = 5'h0F;
      CMD_CORR: base_of = 5'h12;
      default: base_of = 5'h13;
    endcase
  endfunction

  // Bytes a command transfers; interrupt data grows in alarm mode
  function automatic logic [2:0] len_of(input logic [2:0] cmd,
                                        input logic [7:0] status2);
    case (cmd)
      CMD_RTD1: len_of = 3'h7;
      CMD_RTD2: len_of = 3'h3;
      CMD_INTD1, CMD_INTD2:
        len_of = status2[ALARM_MODE_BIT] ? 3'h3 : 3'h1;
      default: len_of = 3'h1;
    endcase
  endfunction

endpackage

/* pin_sync.sv */
// Two-stage synchroniser for the serial clock and data pins
module pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out
);

  logic [1:0] meta_reg;
  logic [1:0] meta_next;
  logic [1:0] out_next;

  always_comb begin
    meta_next = pin_in;
    out_next = meta_reg;
  end

  // Idle bus is high, so reset to released
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 2'h3;
      pin_out <= 2'h3;
    end else begin
      meta_reg <= meta_next;
      pin_out <= out_next;
    end
  end

endmodule

/* rtc_two_wire_target.sv */
// Two-wire serial target of a real-time clock, with APB register access
// What this block does
// - Data falling while clock high is a start and begins an access.
// - Data rising while clock high is a stop; return to standby.
// - Data moves in whole bytes; data changes only while clock is low.
// - Data edge with clock high mid-transfer abandons the access.
// - Master releases data after 8th fall; target acks low on 9th.
// - No acknowledgment when the access is irregular.
// - First byte gives device code and command; direction 1 means read.
// - Reads shift out from bit 7; master acks every byte but last.
// - Direction 0 means write; target acks each byte up to the command length.
// - Interrupt data length follows second status register mode.
// - Command select bit picks first or second status register.
// - Command select bit picks first or second interrupt data register.
// - Without bus events the interface keeps its state indefinitely.
// - Stop resets the interface, but is ignored while target drives low.
// - Recovery during a write ack may still complete that write.
module rtc_two_wire_target (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ======================================================
  // Pin synchronisation and bus events
  logic [1:0] pins_s;
  logic scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_ev, stop_ev, drv;

  pin_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({scl_in, sda_in}),
    .pin_out(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_ev = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign drv = ~sda_oe_n;

  // ======================================================
  // State
  rtc_twi_pkg::link_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next, tx_reg, tx_next;
  logic [2:0] cmd_reg, cmd_next, idx_reg, idx_next;
  logic rw_reg, rw_next, oe_n_next;
  logic [7:0] mem [0:rtc_twi_pkg::MEM_BYTES-1];
  logic link_we;
  logic [4:0] link_wa, cur_addr;
  logic [2:0] cur_len;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [4:0] sel_reg, sel_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next, apb_acc, apb_we;

  // Command low bit selects the paired register by base offset
  assign cur_addr = rtc_twi_pkg::base_of(cmd_reg) +
                    {2'h0, idx_reg};
  assign cur_len = rtc_twi_pkg::len_of(cmd_reg, mem[1]);

  // ======================================================
  // Link next-state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    cmd_next = cmd_reg;
    idx_next = idx_reg;
    rw_next = rw_reg;
    oe_n_next = sda_oe_n;
    link_we = 1'b0;
    link_wa = cur_addr;
    case (state_reg)
      rtc_twi_pkg::st_addr, rtc_twi_pkg::st_wr: begin
        if (scl_rise) begin
          sh_next = {sh_reg[6:0], sda_s};
          cnt_next = cnt_reg + 4'h1;
        end else if (scl_fall && cnt_reg == rtc_twi_pkg::BYTE_BITS) begin
          if (state_reg == rtc_twi_pkg::st_addr) begin
            if (sh_reg[7:4] == rtc_twi_pkg::DEV_CODE && ctrl_reg[0]) begin
              cmd_next = sh_reg[3:1];
              rw_next = sh_reg[0];
              idx_next = 3'h0;
              state_next = rtc_twi_pkg::st_ack;
              oe_n_next = 1'b0;
            end else begin
              state_next = rtc_twi_pkg::st_wait;
            end
          end else if (idx_reg < cur_len) begin
            link_we = 1'b1;
            idx_next = idx_reg + 3'h1;
            state_next = rtc_twi_pkg::st_ack;
            oe_n_next = 1'b0;
          end else begin
            state_next = rtc_twi_pkg::st_wait;
          end
        end
      end
      rtc_twi_pkg::st_ack: begin
        if (scl_fall) begin
          cnt_next = 4'h0;
          if (rw_reg) begin
            tx_next = mem[cur_addr];
            idx_next = idx_reg + 3'h1;
            oe_n_next = mem[cur_addr][7];
            state_next = rtc_twi_pkg::st_tx;
          end else begin
            oe_n_next = 1'b1;
            state_next = rtc_twi_pkg::st_wr;
          end
        end
      end
      rtc_twi_pkg::st_tx: begin
        if (scl_rise) begin
          cnt_next = cnt_reg + 4'h1;
        end else if (scl_fall) begin
          if (cnt_reg == rtc_twi_pkg::BYTE_BITS) begin
            oe_n_next = 1'b1;
            state_next = rtc_twi_pkg::st_mack;
          end else begin
            tx_next = {tx_reg[6:0], 1'b0};
            oe_n_next = tx_reg[6];
          end
        end
      end
      rtc_twi_pkg::st_mack: begin
        if (scl_rise) begin
          sh_next = {sh_reg[7:1], sda_s};
          cnt_next = rtc_twi_pkg::MACK_MARK;
        end else if (scl_fall && cnt_reg == rtc_twi_pkg::MACK_MARK) begin
          cnt_next = 4'h0;
          // No-ack, or a group read past its end, ends the read
          if (!sh_reg[0] && idx_reg < cur_len) begin
            tx_next = mem[cur_addr];
            idx_next = idx_reg + 3'h1;
            oe_n_next = mem[cur_addr][7];
            state_next = rtc_twi_pkg::st_tx;
          end else begin
            state_next = rtc_twi_pkg::st_wait;
          end
        end
      end
      default: begin
      end
    endcase
    // Conditions only count while the line is released by us
    if (!drv && start_ev) begin
      state_next = rtc_twi_pkg::st_addr;
      cnt_next = 4'h0;
      oe_n_next = 1'b1;
    end else if (!drv && stop_ev) begin
      state_next = rtc_twi_pkg::st_idle;
      cnt_next = 4'h0;
      oe_n_next = 1'b1;
    end
  end

  // ======================================================
  // APB next-state
  always_comb begin
    apb_acc = psel & penable & ~pready;
    apb_we = apb_acc & pwrite & (paddr == rtc_twi_pkg::OFS_DATA) &
             (sel_reg < 5'(rtc_twi_pkg::MEM_BYTES));
    pready_next = apb_acc;
    pslverr_next = 1'b0;
    prdata_next = prdata;
    ctrl_next = ctrl_reg;
    sel_next = sel_reg;
    if (apb_acc) begin
      prdata_next = 32'h0000_0000;
      case (paddr)
        rtc_twi_pkg::OFS_CTRL: begin
          if (pwrite) ctrl_next = pwdata[7:0];
          else prdata_next = {24'h00_0000, ctrl_reg};
        end
        rtc_twi_pkg::OFS_STATUS: begin
          if (!pwrite) prdata_next = {22'h00_0000, idx_reg, cmd_reg,
                                      rw_reg, 3'(state_reg)};
        end
        rtc_twi_pkg::OFS_INDEX: begin
          if (pwrite) sel_next = pwdata[4:0];
          else prdata_next = {27'h000_0000, sel_reg};
        end
        rtc_twi_pkg::OFS_DATA: begin
          if (!pwrite && sel_reg < 5'(rtc_twi_pkg::MEM_BYTES))
            prdata_next = {24'h00_0000, mem[sel_reg]};
        end
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  // ======================================================
  // Registers
  // Only rst, start or stop resets the link; no timeout, so a stuck
  // transfer stays put until the master recovers it
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= rtc_twi_pkg::st_idle;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      cmd_reg <= 3'h0;
      idx_reg <= 3'h0;
      rw_reg <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      ctrl_reg <= rtc_twi_pkg::CTRL_RST;
      sel_reg <= 5'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      cmd_reg <= cmd_next;
      idx_reg <= idx_next;
      rw_reg <= rw_next;
      sda_oe_n <= oe_n_next;
      sda_out <= 1'b0;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      ctrl_reg <= ctrl_next;
      sel_reg <= sel_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // Byte store; the link wins a same-cycle write
  always_ff @(posedge clk) begin
    if (link_we) mem[link_wa] <= sh_reg;
    else if (apb_we) mem[sel_reg] <= pwdata[7:0];
  end

  // ======================================================
  // Checks
  property p_start;
    @(posedge clk) disable iff (rst)
      (start_ev && !drv) |=> (state_reg == rtc_twi_pkg::st_addr &&
                              cnt_reg == 4'h0);
  endproperty
  a_start: assert property (p_start)
    else $error("start not taken");

  property p_stop;
    @(posedge clk) disable iff (rst)
      (stop_ev && !drv) |=> (state_reg == rtc_twi_pkg::st_idle && sda_oe_n);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not return to standby");

  property p_stop_ignored;
    @(posedge clk) disable iff (rst)
      (drv && !scl_fall) |=> ($stable(state_reg) && !sda_oe_n);
  endproperty
  a_stop_ignored: assert property (p_stop_ignored)
    else $error("stop accepted while driving low");

  property p_ack_drives;
    @(posedge clk) disable iff (rst)
      (state_reg == rtc_twi_pkg::st_ack) |-> !sda_oe_n;
  endproperty
  a_ack_drives: assert property (p_ack_drives)
    else $error("ack phase without low drive");

  property p_bad_code;
    @(posedge clk) disable iff (rst)
      (state_reg == rtc_twi_pkg::st_addr && scl_fall && !start_ev &&
       !stop_ev && cnt_reg == 4'h8 && sh_reg[7:4] != rtc_twi_pkg::DEV_CODE)
      |=> (sda_oe_n && state_reg == rtc_twi_pkg::st_wait);
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("foreign device code acknowledged");

  property p_read_mode;
    @(posedge clk) disable iff (rst)
      (state_reg == rtc_twi_pkg::st_ack && rw_reg && scl_fall && !start_ev)
      |=> (state_reg == rtc_twi_pkg::st_tx && sda_oe_n == tx_reg[7]);
  endproperty
  a_read_mode: assert property (p_read_mode)
    else $error("read did not start with bit 7");

  property p_tx_bit;
    @(posedge clk) disable iff (rst)
      (state_reg == rtc_twi_pkg::st_tx) |-> (sda_oe_n == tx_reg[7]);
  endproperty
  a_tx_bit: assert property (p_tx_bit)
    else $error("transmitted bit differs from shift msb");

  property p_hold;
    @(posedge clk) disable iff (rst)
      (!scl_rise && !scl_fall && !start_ev && !stop_ev)
      |=> ($stable(state_reg) && $stable(sda_oe_n));
  endproperty
  a_hold: assert property (p_hold)
    else $error("interface moved without bus activity");

  property p_nack_ends;
    @(posedge clk) disable iff (rst)
      (state_reg == rtc_twi_pkg::st_mack && scl_fall && sh_reg[0] &&
       cnt_reg == rtc_twi_pkg::MACK_MARK && !start_ev && !stop_ev)
      |=> state_reg == rtc_twi_pkg::st_wait;
  endproperty
  a_nack_ends: assert property (p_nack_ends)
    else $error("read went on after no-ack");

endmodule

/* twi_master_model.sv */
// Bus master model that drives the serial clock and data lines
module twi_master_model (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========
  // Line phases, a quarter of the 160 ns link period each
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end

  task automatic quarter();
    repeat (4) @(posedge clk);
  endtask

  task automatic start();
    sda <= 1'h1;
    quarter();
    scl <= 1'h1;
    quarter();
    sda <= 1'h0;
    quarter();
    scl <= 1'h0;
    quarter();
  endtask

  task automatic stop();
    sda <= 1'h0;
    quarter();
    scl <= 1'h1;
    quarter();
    sda <= 1'h1;
    quarter();
  endtask

  // ==========
  // Data moves only while the clock is low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda <= b;
    quarter();
    scl <= 1'h1;
    quarter();
    r = sda_wire;
    quarter();
    scl <= 1'h0;
    quarter();
  endtask

  task automatic byte_io(input logic [7:0] d, output logic [7:0] r);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
  endtask

  // Frees a target stuck driving low, whatever it was doing
  task automatic recover();
    logic b;
    start();
    repeat (63) bit_io(1'h1, b);
    stop();
  endtask
endmodule

/* rtc_two_wire_target_tb_top.sv */
// Testbench of the two-wire target with a bus master model and APB
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end

module rtc_two_wire_target_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sda_out, sda_oe_n, scl, m_sda, a;
  logic [7:0] v, w, r, u;
  int n = 0;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 32'ha37a;
  // Open drain with pull-up: low if either party pulls
  wire sda_wire = m_sda & (sda_oe_n | sda_out);

  initial begin
    forever #5 clk = ~clk;
  end

  rtc_two_wire_target i_dut (.clk(clk), .rst(rst), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  twi_master_model i_mst (.clk(clk), .sda_wire(sda_wire), .scl(scl),
    .sda(m_sda));

  // ==========
  // Reporting
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      summarize();
    end
  end

  // ==========
  // APB master; expectation noted at setup, checked when pready shows
  task automatic apb(input logic wr_n, input logic [7:0] ad,
                     input logic [31:0] d, input logic [32:0] e,
                     input logic [32:0] m);
    @(posedge clk);
    exp_q.push_back(e);
    msk_q.push_back(m);
    psel <= 1'h1;
    pwrite <= wr_n;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  always @(posedge clk) begin
    if (pready === 1'h1 && exp_q.size() > 0) begin
      `CHK({pslverr, prdata} & msk_q[0], exp_q[0] & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  task automatic rd(input logic [7:0] ad, input logic [31:0] e,
                    input logic [31:0] m);
    apb(1'h0, ad, 32'h0, {1'h0, e}, {1'h1, m});
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'h1, ad, d, 33'h0, {1'h1, 32'h0});
  endtask

  task automatic poke(input logic [4:0] i, input logic [7:0] d);
    wr(rtc_twi_pkg::OFS_INDEX, {27'h0, i});
    wr(rtc_twi_pkg::OFS_DATA, {24'h0, d});
  endtask

  task automatic peek(input logic [4:0] i, input logic [7:0] e);
    wr(rtc_twi_pkg::OFS_INDEX, {27'h0, i});
    rd(rtc_twi_pkg::OFS_DATA, {24'h0, e}, 32'hFFFFFFFF);
  endtask

  // ==========
  // Link bytes: master releases for the 9th clock, or acks a read
  task automatic snd(input logic [7:0] d, input logic ea);
    i_mst.byte_io(d, r);
    i_mst.bit_io(1'h1, a);
    `CHK(a, ea)
  endtask

  task automatic rcv(input logic [7:0] e, input logic ma);
    i_mst.byte_io(8'hFF, r);
    `CHK(r, e)
    i_mst.bit_io(ma, a);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    // Scaled-down quiet time after power-on
    repeat (4) @(posedge clk);
    rd(rtc_twi_pkg::OFS_CTRL, 32'h1, 32'hFFFFFFFF);
    rd(rtc_twi_pkg::OFS_STATUS, 32'h0, 32'h7);
    apb(1'h0, 8'h10, 32'h0, {1'h1, 32'h0}, {1'h1, 32'hFFFFFFFF});
    // Write second status with alarm mode, then first status with one byte too many
    v = 8'($random(seed)) | 8'h20;
    w = 8'($random(seed)) & 8'h3F;
    i_mst.start();
    snd(8'h62, 1'h0);
    snd(v, 1'h0);
    i_mst.stop();
    i_mst.start();
    snd(8'h60, 1'h0);
    snd(w, 1'h0);
    snd(8'h5A, 1'h1);
    i_mst.stop();
    peek(5'h01, v);
    peek(5'h00, w);
    // Both interrupt data groups are three bytes in alarm mode
    for (int k = 0; k < 6; k++) poke(5'(5'hC + k), 8'(v + k));
    for (int s = 0; s < 2; s++) begin
      i_mst.start();
      snd({4'h6, 3'(3'h4 + s), 1'h1}, 1'h0);
      for (int k = 0; k < 3; k++) rcv(8'(v + 3 * s + k), k == 2);
      i_mst.stop();
    end
    poke(5'h01, v & 8'hDF);
    i_mst.start();
    snd(8'h69, 1'h0);
    rcv(v, 1'h0);
    rcv(8'hFF, 1'h1);
    i_mst.stop();
    // Foreign code, then answering switched off
    i_mst.start();
    snd(8'h52, 1'h1);
    i_mst.stop();
    wr(rtc_twi_pkg::OFS_CTRL, 32'h0);
    i_mst.start();
    snd(8'h62, 1'h1);
    i_mst.stop();
    wr(rtc_twi_pkg::OFS_CTRL, 32'h1);
    // Stop in mid-byte abandons the write
    i_mst.start();
    snd(8'h62, 1'h0);
    repeat (4) i_mst.bit_io(1'h0, a);
    i_mst.stop();
    rd(rtc_twi_pkg::OFS_STATUS, 32'h0, 32'h7);
    peek(5'h01, v & 8'hDF);
    // Stop while the target drives a zero, then recovery
    i_mst.start();
    snd(8'h61, 1'h0);
    i_mst.bit_io(1'h1, a);
    `CHK(a, 1'h0)
    i_mst.stop();
    `CHK(sda_oe_n, 1'h0)
    `CHK(sda_out, 1'h0)
    rd(rtc_twi_pkg::OFS_STATUS, 32'h4, 32'h7);
    i_mst.recover();
    repeat (8) @(posedge clk);
    `CHK(sda_oe_n, 1'h1)
    rd(rtc_twi_pkg::OFS_STATUS, 32'h0, 32'h7);
    i_mst.start();
    snd(8'h60, 1'h0);
    snd(v, 1'h0);
    i_mst.stop();
    peek(5'h00, v);
    // Remaining groups: written, then read straight back in time
    for (int c = 2; c < 8; c++) begin
      if (c != 4 && c != 5) begin
        n = (c == 2) ? 7 : (c == 3) ? 3 : 1;
        u = 8'($random(seed));
        i_mst.start();
        snd({4'h6, 3'(c), 1'h0}, 1'h0);
        for (int k = 0; k < n; k++) snd(8'(u + k), 1'h0);
        i_mst.stop();
        i_mst.start();
        snd({4'h6, 3'(c), 1'h1}, 1'h0);
        for (int k = 0; k < n; k++) rcv(8'(u + k), k == n - 1);
        i_mst.stop();
      end
    end
    summarize();
  end
endmodule
